/* src/clamp_timing_and_output_control.sv */
// clamp timing, sync handling and pixel output port control
// assumes a decoded serial register port on core_clk_in and that all
// pins (line sync, coast, external clamp, external pixel clock) are async
//
// Behaviour
// - each colour offset is six bits held in bits 7..2 of its register
// - offset 31 clamps to code 0, 63 to 31, 0 to -31
// - all three offset registers reset to 80h
// - internal clamp starts placement pixel periods after sync trailing edge, one period for placement 0
// - internal clamp then lasts exactly duration pixel periods, one period for duration 0
// - external clamp source ignores placement and duration entirely
// - placement and duration registers reset to 80h
// - port select clear: all to A, B tristate; set: alternate; reset set
// - timing bit set: A and data clock delayed half period, else split
// - timing bit ignored in single port mode, resets to 1
// - sync polarity bit picks active level; sample lead, clamp trail; reset 1
// - active coast makes clock generator ignore sync; polarity resets 1
// - clamp source bit: 0 internal timer, 1 external pin; reset 0
// - clamp polarity 0 clamps on low pin, 1 on high; reset 1
// - clock source 0 PLL, 1 external pin; divide ignored; reset 0
`timescale 1ns/100ps

module clamp_timing_and_output_control
  import clamp_ctrl_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire clamp_ctrl_pkg::reg_byte_t reg_addr_in,
  input wire clamp_ctrl_pkg::reg_byte_t reg_wdata_in,
  input wire logic line_sync_pin_in,
  input wire logic coast_pin_in,
  input wire logic ext_clamp_pin_in,
  input wire logic external_pixel_clock_pin_in,
  input wire logic pll_pixel_tick_in,
  input wire clamp_ctrl_pkg::reg_byte_t pixel_data_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic clamp_active_out,
  output logic sync_lead_out,
  output logic coast_active_out,
  output logic use_pll_divider_out,
  output clamp_ctrl_pkg::level_t red_clamp_level_out,
  output clamp_ctrl_pkg::level_t green_clamp_level_out,
  output clamp_ctrl_pkg::level_t blue_clamp_level_out,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out,
  output logic port_b_oe_out,
  output logic output_data_clock_out
);
  import clamp_ctrl_pkg::*;

  // ****************
  // helpers
  // ****************
  // offset field minus nominal, top code limited to +31
  function automatic level_t clamp_level(input reg_byte_t r);
    level_t lv;
    lv = level_t'({1'b0, r[`OFFSET_FIELD_HI:`OFFSET_FIELD_LO]}) -
         level_t'(`OFFSET_NOMINAL);
    if (lv > level_t'(`LEVEL_MAX))
    begin
      lv = level_t'(`LEVEL_MAX);
    end
    return lv;
  endfunction : clamp_level

  function automatic count_t count_down(input count_t c);
    return count_t'(c - `COUNT_ONE);
  endfunction : count_down

  // ****************
  // registers
  // ****************
  reg_byte_t red_ff, green_ff, blue_ff, place_ff, dur_ff, ctrl_ff;
  reg_byte_t nxt_red, nxt_green, nxt_blue, nxt_place, nxt_dur, nxt_ctrl;
  reg_byte_t rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;

  always_comb
  begin
    nxt_red = red_ff;
    nxt_green = green_ff;
    nxt_blue = blue_ff;
    nxt_place = place_ff;
    nxt_dur = dur_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = reg_wr_in | reg_rd_in;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        `OFS_RED_OFFSET: nxt_red = reg_wdata_in & `OFFSET_RSVD_MASK;
        `OFS_GREEN_OFFSET: nxt_green = reg_wdata_in & `OFFSET_RSVD_MASK;
        `OFS_BLUE_OFFSET: nxt_blue = reg_wdata_in & `OFFSET_RSVD_MASK;
        `OFS_CLAMP_PLACEMENT: nxt_place = reg_wdata_in;
        `OFS_CLAMP_DURATION: nxt_dur = reg_wdata_in;
        `OFS_GENERAL_CONTROL: nxt_ctrl = reg_wdata_in & `CTRL_RSVD_MASK;
        default: nxt_ack = 1'b0;
      endcase
    end
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `OFS_RED_OFFSET: nxt_rdata = red_ff;
        `OFS_GREEN_OFFSET: nxt_rdata = green_ff;
        `OFS_BLUE_OFFSET: nxt_rdata = blue_ff;
        `OFS_CLAMP_PLACEMENT: nxt_rdata = place_ff;
        `OFS_CLAMP_DURATION: nxt_rdata = dur_ff;
        `OFS_GENERAL_CONTROL: nxt_rdata = ctrl_ff;
        default:
        begin
          nxt_rdata = 8'h00;
          nxt_ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      red_ff <= `RST_OFFSET;
      green_ff <= `RST_OFFSET;
      blue_ff <= `RST_OFFSET;
      place_ff <= `RST_CLAMP_TIMING;
      dur_ff <= `RST_CLAMP_TIMING;
      // control byte reset to f4h: port select, timing and all three polarity bits set
      ctrl_ff <= `RST_GENERAL_CONTROL;
      rdata_ff <= 8'h00;
      ack_ff <= 1'b0;
    end
    else
    begin
      red_ff <= nxt_red;
      green_ff <= nxt_green;
      blue_ff <= nxt_blue;
      place_ff <= nxt_place;
      dur_ff <= nxt_dur;
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
    end
  end

  logic dual_mode, par_mode, sync_pol, coast_pol, ext_clamp, clamp_pol;
  logic ext_clock;
  assign dual_mode = ctrl_ff[`BIT_DUAL_PORT];
  assign par_mode = ctrl_ff[`BIT_OUT_TIMING];
  assign sync_pol = ctrl_ff[`BIT_SYNC_POL];
  assign coast_pol = ctrl_ff[`BIT_COAST_POL];
  assign ext_clamp = ctrl_ff[`BIT_CLAMP_SRC];
  assign clamp_pol = ctrl_ff[`BIT_CLAMP_POL];
  assign ext_clock = ctrl_ff[`BIT_CLOCK_SRC];

  // ****************
  // pin synchronisers
  // ****************
  logic [3:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
      pin_prev_ff <= 4'h0;
    end
    else
    begin
      pin_meta_ff <= {external_pixel_clock_pin_in, ext_clamp_pin_in,
                      coast_pin_in, line_sync_pin_in};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // sync normalised to active-high by polarity bit
  logic sync_act, sync_prev_act, sync_lead, sync_trail;
  assign sync_act = pin_sync_ff[0] ~^ sync_pol;
  assign sync_prev_act = pin_prev_ff[0] ~^ sync_pol;
  assign sync_lead = sync_act & ~sync_prev_act;
  assign sync_trail = ~sync_act & sync_prev_act;

  // pixel tick from PLL or external pin rising edge
  logic pixel_tick;
  assign pixel_tick = ext_clock ? (pin_sync_ff[3] & ~pin_prev_ff[3])
                                : pll_pixel_tick_in;

  // ****************
  // clamp timer
  // ****************
  clamp_state_t state_ff, nxt_state;
  count_t cnt_ff, nxt_cnt;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (sync_trail)
    begin
      nxt_state = CLAMP_WAIT;
      nxt_cnt = place_ff;
    end
    else if (pixel_tick)
    begin
      case (state_ff)
        CLAMP_WAIT:
        begin
          if (cnt_ff <= `COUNT_ONE)
          begin
            nxt_state = CLAMP_ACTIVE;
            nxt_cnt = dur_ff;
          end
          else
          begin
            nxt_cnt = count_down(cnt_ff);
          end
        end
        CLAMP_ACTIVE:
        begin
          if (cnt_ff <= `COUNT_ONE)
          begin
            nxt_state = CLAMP_IDLE;
            nxt_cnt = `COUNT_ZERO;
          end
          else
          begin
            nxt_cnt = count_down(cnt_ff);
          end
        end
        CLAMP_IDLE: nxt_cnt = `COUNT_ZERO;
        default:
        begin
          nxt_state = CLAMP_IDLE;
          nxt_cnt = `COUNT_ZERO;
        end
      endcase
    end
  end

  // external pin polarity; timer ignored when external
  logic nxt_clamp;
  assign nxt_clamp = ext_clamp ? (pin_sync_ff[2] ~^ clamp_pol)
                               : (nxt_state == CLAMP_ACTIVE);

  // coast level by its polarity bit
  logic nxt_coast;
  assign nxt_coast = pin_sync_ff[1] ~^ coast_pol;

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state_ff <= CLAMP_IDLE;
      cnt_ff <= `COUNT_ZERO;
      clamp_active_out <= 1'b0;
      coast_active_out <= 1'b0;
      sync_lead_out <= 1'b0;
      use_pll_divider_out <= 1'b1;
      red_clamp_level_out <= '0;
      green_clamp_level_out <= '0;
      blue_clamp_level_out <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      clamp_active_out <= nxt_clamp;
      coast_active_out <= nxt_coast;
      sync_lead_out <= sync_lead;
      use_pll_divider_out <= ~ext_clock;
      red_clamp_level_out <= clamp_level(red_ff);
      green_clamp_level_out <= clamp_level(green_ff);
      blue_clamp_level_out <= clamp_level(blue_ff);
    end
  end

  // ****************
  // output ports
  // ****************
  // first pixel after the leading edge goes to port A
  logic phase_b_ff, nxt_phase_b;
  reg_byte_t a_ff, b_ff, hold_a_ff, nxt_a, nxt_b, nxt_hold_a;
  logic dck_ff, nxt_dck, boe_ff, nxt_boe;

  always_comb
  begin
    nxt_phase_b = phase_b_ff;
    nxt_a = a_ff;
    nxt_b = b_ff;
    nxt_hold_a = hold_a_ff;
    nxt_dck = dck_ff;
    // port B driven only in dual mode
    nxt_boe = dual_mode;
    if (sync_lead)
    begin
      nxt_phase_b = 1'b0;
      // data clock low at line start; first pixel gives a rise, or the second in dual mode with timing bit set
      nxt_dck = 1'b0;
    end
    else if (pixel_tick)
    begin
      if (!dual_mode)
      begin
        // timing bit has no effect here
        nxt_a = pixel_data_in;
        nxt_dck = ~dck_ff;
      end
      else if (!phase_b_ff)
      begin
        nxt_phase_b = 1'b1;
        if (par_mode)
        begin
          // A held back half a clock period
          nxt_hold_a = pixel_data_in;
          nxt_dck = 1'b0;
        end
        else
        begin
          nxt_a = pixel_data_in;
          nxt_dck = 1'b1;
        end
      end
      else
      begin
        nxt_phase_b = 1'b0;
        nxt_b = pixel_data_in;
        if (par_mode)
        begin
          // both ports change with the rising edge
          nxt_a = hold_a_ff;
          nxt_dck = 1'b1;
        end
        else
        begin
          nxt_dck = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      phase_b_ff <= 1'b0;
      a_ff <= 8'h00;
      b_ff <= 8'h00;
      hold_a_ff <= 8'h00;
      dck_ff <= 1'b0;
      boe_ff <= 1'b1;
    end
    else
    begin
      phase_b_ff <= nxt_phase_b;
      a_ff <= nxt_a;
      b_ff <= nxt_b;
      hold_a_ff <= nxt_hold_a;
      dck_ff <= nxt_dck;
      boe_ff <= nxt_boe;
    end
  end

  assign port_a_out = a_ff;
  assign port_b_out = b_ff;
  assign port_b_oe_out = boe_ff;
  assign output_data_clock_out = dck_ff;
  assign reg_rdata_out = rdata_ff;
  assign reg_ack_out = ack_ff;

endmodule : clamp_timing_and_output_control

/* src/clamp_ctrl_defines.svh */
// register offsets, reset values, field positions and widths
// assumes inclusion by bare name from the package; the design itself does not include it
`ifndef CLAMP_CTRL_DEFINES_SVH
`define CLAMP_CTRL_DEFINES_SVH

// ****************
// register offsets
// ****************
`define OFS_RED_OFFSET 8'h05
`define OFS_GREEN_OFFSET 8'h06
`define OFS_BLUE_OFFSET 8'h07
`define OFS_CLAMP_PLACEMENT 8'h08
`define OFS_CLAMP_DURATION 8'h09
`define OFS_GENERAL_CONTROL 8'h0a

// ***************
// reset values
// ***************
`define RST_OFFSET 8'h80
`define RST_CLAMP_TIMING 8'h80
`define RST_GENERAL_CONTROL 8'hf4

// ******************
// field positions
// ******************
`define OFFSET_FIELD_HI 7
`define OFFSET_FIELD_LO 2
`define OFFSET_RSVD_MASK 8'hfc
`define CTRL_RSVD_MASK 8'hfe
`define BIT_DUAL_PORT 7
`define BIT_OUT_TIMING 6
`define BIT_SYNC_POL 5
`define BIT_COAST_POL 4
`define BIT_CLAMP_SRC 3
`define BIT_CLAMP_POL 2
`define BIT_CLOCK_SRC 1

// ***************************
// widths and clamp code math
// ***************************
`define OFFSET_W 6
`define LEVEL_W 7
`define COUNT_W 8
`define OFFSET_NOMINAL 7'h1f
`define LEVEL_MAX 7'h1f
`define COUNT_ONE 8'h01
`define COUNT_ZERO 8'h00

`endif

/* src/clamp_ctrl_pkg.sv */
// types shared by the clamp timing and output control block
// assumes the defines header sits on the include path
`include "clamp_ctrl_defines.svh"

package clamp_ctrl_pkg;

  typedef logic [`COUNT_W-1:0] count_t;
  typedef logic [`OFFSET_W-1:0] offset_t;
  typedef logic signed [`LEVEL_W-1:0] level_t;
  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    CLAMP_IDLE,
    CLAMP_WAIT,
    CLAMP_ACTIVE
  } clamp_state_t;

endpackage : clamp_ctrl_pkg

/* verification/clamp_monitor.sv */
// port checks for clamp timing and output control
// assumes bind onto the design top; mirrors the control byte from writes
`timescale 1ns/100ps
module clamp_monitor
  import clamp_ctrl_pkg::*;
(
  input logic core_clk_in,
  input logic rst_in,
  input logic reg_wr_in,
  input logic reg_rd_in,
  input clamp_ctrl_pkg::reg_byte_t reg_addr_in,
  input clamp_ctrl_pkg::reg_byte_t reg_wdata_in,
  input logic coast_pin_in,
  input logic ext_clamp_pin_in,
  input logic pll_pixel_tick_in,
  input logic [7:0] reg_rdata_out,
  input logic reg_ack_out,
  input logic clamp_active_out,
  input logic coast_active_out,
  input logic use_pll_divider_out,
  input logic port_b_oe_out
);
  reg_byte_t ctrl_ff;
  reg_byte_t nxt_ctrl;
  logic req;
  logic mapped;
  assign req = reg_wr_in | reg_rd_in;
  assign mapped = reg_addr_in >= 8'h05 && reg_addr_in <= 8'h0a;
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (rst_in)
      nxt_ctrl = 8'hf4;
    else if (reg_wr_in && reg_addr_in == 8'h0a)
      nxt_ctrl = reg_wdata_in & 8'hfe;
  end
  always_ff @(posedge core_clk_in)
    ctrl_ff <= nxt_ctrl;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  property p_map_ack;
    req && mapped |=> reg_ack_out;
  endproperty
  a_map_ack: assert property (p_map_ack) else $error("ack missing");
  property p_unmap_ack;
    req && !mapped |=> !reg_ack_out;
  endproperty
  a_unmap_ack: assert property (p_unmap_ack) else $error("stray ack");
  property p_oe;
    $stable(ctrl_ff) [*3] |-> port_b_oe_out == ctrl_ff[7];
  endproperty
  a_oe: assert property (p_oe) else $error("port b enable");
  property p_pll;
    $stable(ctrl_ff) [*3] |-> use_pll_divider_out == !ctrl_ff[1];
  endproperty
  a_pll: assert property (p_pll) else $error("divider use");
  property p_ext;
    (ctrl_ff[3] && $stable(ctrl_ff) && $stable(ext_clamp_pin_in)) [*5]
      |-> clamp_active_out == (ext_clamp_pin_in ~^ ctrl_ff[2]);
  endproperty
  a_ext: assert property (p_ext) else $error("ext clamp");
  property p_coast;
    ($stable(ctrl_ff) && $stable(coast_pin_in)) [*5]
      |-> coast_active_out == (coast_pin_in ~^ ctrl_ff[4]);
  endproperty
  a_coast: assert property (p_coast) else $error("coast level");
  property p_tick;
    !ctrl_ff[3] && !ctrl_ff[1] && $stable(ctrl_ff) && $rose(clamp_active_out)
      |-> $past(pll_pixel_tick_in);
  endproperty
  a_tick: assert property (p_tick) else $error("clamp off tick");
  property p_rd_ctrl;
    reg_rd_in && !reg_wr_in && reg_addr_in == 8'h0a |=> reg_rdata_out == ctrl_ff;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl read");
endmodule : clamp_monitor

/* verification/display_latch.sv */
// display side latch of the pixel ports
// assumes the data clock is registered in the core clock domain
`timescale 1ns/100ps
module display_latch
  import clamp_ctrl_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic output_data_clock_in,
  input wire logic par_in,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  output clamp_ctrl_pkg::reg_byte_t lat_a_out,
  output clamp_ctrl_pkg::reg_byte_t lat_b_out
);
  logic dck_ff;
  // rising latches a, b on rise or fall
  always @(posedge core_clk_in)
  begin
    dck_ff <= output_data_clock_in;
    if (output_data_clock_in && !dck_ff)
      lat_a_out <= port_a_in;
    if ((output_data_clock_in ~^ par_in) && (dck_ff ^ par_in))
      lat_b_out <= port_b_in;
  end
endmodule : display_latch

/* verification/clamp_timing_and_output_control_tb.sv */
// bench for registers, clamp timer, pins and pixel ports
// assumes design, monitor and display latch are compiled first
`timescale 1ns/100ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %h got %h", n, e, a); end end
module clamp_timing_and_output_control_tb;
  import clamp_ctrl_pkg::*;
  logic core_clk_in = 1'h0, rst_in = 1'h1, reg_wr_in = 1'h0, k;
  logic reg_rd_in = 1'h0, line_sync_pin_in = 1'h0, coast_pin_in = 1'h0;
  logic ext_clamp_pin_in = 1'h0, external_pixel_clock_pin_in = 1'h0;
  logic pll_pixel_tick_in = 1'h0, par = 1'h1;
  reg_byte_t reg_addr_in = 8'h00, reg_wdata_in = 8'h00, pixel_data_in = 8'h00;
  reg_byte_t lat_a, lat_b;
  logic [7:0] reg_rdata_out, port_a_out, port_b_out;
  logic reg_ack_out, clamp_active_out, sync_lead_out, coast_active_out;
  logic use_pll_divider_out, port_b_oe_out, output_data_clock_out;
  level_t red_clamp_level_out, green_clamp_level_out, blue_clamp_level_out;
  int fail_count = 0, samples_checked = 0, n;
  always #10 core_clk_in = ~core_clk_in;
  clamp_timing_and_output_control i_clamp_timing_and_output_control (.*);
  // released port b seen inverted, not holding its value
  display_latch i_display_latch (.core_clk_in(core_clk_in),
    .output_data_clock_in(output_data_clock_out), .par_in(par),
    .port_a_in(port_a_out),
    .port_b_in(port_b_oe_out ? port_b_out : ~port_b_out),
    .lat_a_out(lat_a), .lat_b_out(lat_b));
  task automatic xfer(input logic w, input reg_byte_t a, input reg_byte_t d);
    @(negedge core_clk_in);
    reg_wr_in = w;
    reg_rd_in = ~w;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge core_clk_in);
    k = reg_ack_out;
    reg_wr_in = 1'h0;
    reg_rd_in = 1'h0;
    @(negedge core_clk_in);
    k = k | reg_ack_out;
  endtask : xfer
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    xfer(1'h1, a, d);
    `CHK("ack", 1'h1, k)
  endtask : wr
  task automatic rdchk(input reg_byte_t a, input reg_byte_t e);
    xfer(1'h0, a, 8'h00);
    `CHK("rdata", e, reg_rdata_out)
  endtask : rdchk
  task automatic tick(input reg_byte_t d);
    @(negedge core_clk_in);
    pll_pixel_tick_in = 1'h1;
    pixel_data_in = d;
    @(negedge core_clk_in);
    pll_pixel_tick_in = 1'h0;
    @(negedge core_clk_in);
  endtask : tick
  task automatic sync(input logic act);
    n = 0;
    for (int i = 0; i < 10; i++)
    begin
      @(negedge core_clk_in);
      line_sync_pin_in = (i < 4) ? act : ~act;
      n += sync_lead_out;
    end
  endtask : sync
  task automatic t_regs;
    for (int a = 5; a < 10; a++)
      rdchk(8'(a), 8'h80);
    rdchk(8'h0a, 8'hf4);
    `CHK("pll", 1'h1, use_pll_divider_out)
    `CHK("red", 7'h01, red_clamp_level_out)
    wr(8'h05, 8'hff);
    rdchk(8'h05, 8'hfc);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h7c);
    `CHK("red", 7'h1f, red_clamp_level_out)
    `CHK("green", 7'h61, green_clamp_level_out)
    `CHK("blue", 7'h00, blue_clamp_level_out)
    xfer(1'h1, 8'h0b, 8'h55);
    `CHK("unmapped ack", 1'h0, k)
    xfer(1'h0, 8'h0b, 8'h00);
    `CHK("unmapped rdata", 8'h00, reg_rdata_out)
    $display("register test done");
  endtask : t_regs
  task automatic t_pins;
    // placement and duration always written nonzero
    wr(8'h08, 8'h01);
    wr(8'h09, 8'h01);
    wr(8'h0a, 8'hfc);
    ext_clamp_pin_in = 1'h1;
    coast_pin_in = 1'h1;
    repeat (6) @(negedge core_clk_in);
    `CHK("ext clamp", 1'h1, clamp_active_out)
    `CHK("coast", 1'h1, coast_active_out)
    wr(8'h0a, 8'he8);
    repeat (6) @(negedge core_clk_in);
    `CHK("ext clamp low", 1'h0, clamp_active_out)
    `CHK("coast low", 1'h0, coast_active_out)
    ext_clamp_pin_in = 1'h0;
    coast_pin_in = 1'h0;
    sync(1'h1);
    repeat (4) tick(8'h00);
    `CHK("timer ignored", 1'h1, clamp_active_out)
    wr(8'h0a, 8'hf4);
    $display("pin test done");
  endtask : t_pins
  task automatic t_clamp(input logic pol);
    logic [7:0] seen;
    wr(8'h0a, {2'h3, pol, 5'h14});
    wr(8'h08, 8'h02);
    wr(8'h09, 8'h03);
    line_sync_pin_in = ~pol;
    repeat (6) @(negedge core_clk_in);
    sync(pol);
    `CHK("lead pulses", 32'h1, n)
    for (int i = 0; i < 8; i++)
    begin
      tick(8'h00);
      seen[i] = clamp_active_out;
    end
    `CHK("clamp", 8'h0e, seen)
    line_sync_pin_in = 1'h0;
    wr(8'h0a, 8'hf4);
    $display("clamp test done");
  endtask : t_clamp
  task automatic t_typical;
    int rise;
    int len;
    rise = 0;
    len = 0;
    // typical back porch placement and duration
    wr(8'h08, 8'h08);
    wr(8'h09, 8'h10);
    sync(1'h1);
    for (int i = 1; i <= 32; i++)
    begin
      tick(8'h00);
      if (clamp_active_out && rise == 0)
        rise = i;
      len += clamp_active_out;
    end
    `CHK("typ start", 32'h8, rise)
    `CHK("typ length", 32'h10, len)
    $display("typical clamp test done");
  endtask : t_typical
  task automatic t_ports;
    wr(8'h0a, 8'h74);
    tick(8'h3c);
    `CHK("oe single", 1'h0, port_b_oe_out)
    `CHK("port a", 8'h3c, port_a_out)
    for (int p = 0; p < 2; p++)
    begin
      par = p[0];
      wr(8'h0a, {1'h1, par, 6'h34});
      sync(1'h1);
      tick(8'h11 + 8'(p));
      tick(8'h22 + 8'(p));
      repeat (2) @(negedge core_clk_in);
      `CHK("latched a", 8'h11 + 8'(p), lat_a)
      `CHK("latched b", 8'h22 + 8'(p), lat_b)
    end
    wr(8'h0a, 8'h76);
    pixel_data_in = 8'h69;
    external_pixel_clock_pin_in = 1'h1;
    repeat (5) @(negedge core_clk_in);
    external_pixel_clock_pin_in = 1'h0;
    `CHK("pll off", 1'h0, use_pll_divider_out)
    `CHK("ext pixel", 8'h69, port_a_out)
    $display("port test done");
  endtask : t_ports
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (2) @(negedge core_clk_in);
    rst_in = 1'h0;
    t_regs;
    t_pins;
    t_clamp(1'h1);
    t_clamp(1'h0);
    t_typical;
    t_ports;
    summarize;
  end
  // far longer than the whole sequence needs
  initial
  begin
    #200000;
    fail_count++;
    summarize;
  end
endmodule : clamp_timing_and_output_control_tb
bind clamp_timing_and_output_control clamp_monitor i_clamp_monitor (.*);
